// *** logic/eeprom_pkg.sv ***
/*
  Constants, types and state codes shared by the serial EEPROM slave and its helpers.
  Assumes a single system clock of CLK_FREQ_MHZ and bus pins that are sampled by it.
*/
package eeprom_pkg;

  // ==========================================================================
  // Array organisation
  // ==========================================================================
  localparam int MEM_DEPTH = 256;
  localparam int PAGE_BYTES = 16;
  localparam int ADDR_W = 8;
  localparam int PAGE_W = 4;

  // ==========================================================================
  // Slave address byte
  // ==========================================================================
  localparam logic [3:0] PREFIX_MAIN = 4'hA;
  localparam logic [3:0] PREFIX_ID = 4'hB;
  localparam int ID_LOCK_BIT = 7;

  // ==========================================================================
  // Bit counting within a byte
  // ==========================================================================
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;

  // ==========================================================================
  // Self-timed programming cycle
  // ==========================================================================
  localparam int CLK_FREQ_MHZ = 100;
  localparam int PROG_TIME_US = 4000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_FREQ_MHZ;

  // ==========================================================================
  // Pin bundle and reset values
  // ==========================================================================
  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic unlock;
    logic [2:0] sel;
  } pins_t;

  localparam pins_t PINS_RESET = '{scl: 1'b1, sda: 1'b1, wp: 1'b0, unlock: 1'b0, sel: 3'h0};

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEVADDR = 3'b001,
    ST_WORDADDR = 3'b010,
    ST_WRDATA = 3'b011,
    ST_RDDATA = 3'b100,
    ST_IGNORE = 3'b101
  } slave_state_t;

endpackage

// *** logic/pin_sync.sv ***
/*
  Two-flop synchroniser for a bundle of asynchronous pins.
  Assumes each bit is an independent level; no bit relation is kept across the bundle.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 7,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  if (W < 1) begin : g_chk
    $error("pin_sync needs at least one bit");
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// *** logic/prog_timer.sv ***
/*
  Self-timed programming cycle counter: busy for CYCLES clocks, then a done pulse.
  Assumes start is ignored while busy; reset aborts the cycle without a done pulse.
*/
`timescale 1ns/100ps
module prog_timer #(
  parameter int CYCLES = 400000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  output logic busy_out,
  output logic done_out
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r;

  if (CYCLES < 1) begin : g_chk
    $error("prog_timer needs at least one cycle");
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= busy_out && cnt_r == LAST;
      if (start_in && !busy_out) begin
        busy_out <= 1'b1;
        cnt_r <= '0;
      end else if (busy_out && cnt_r == LAST) begin
        busy_out <= 1'b0;
      end else if (busy_out) begin
        cnt_r <= cnt_r + CW'(1);
      end
    end
  end

  prog_bound_a: assert property (@(posedge clk_in) disable iff (rst_in) // R11
    busy_out |-> cnt_r <= LAST)
    else $error("programming cycle overran its time");

endmodule

// *** logic/eeprom_slave.sv ***
/*
  Two-wire serial EEPROM slave: 256x8 array in 16-byte pages, lockable ID page,
  write protect, address-select pins, open-drain data and self-timed programming.
  Assumes SCL and SDA are sampled by CLK_SYS_IN at least eight times per bus bit
  and that RST_IN carries the power-on reset of the device.
*/
// Behaviour
// R01: Hold 256 bytes in 16-byte pages.
// R02: Ignore bus during reset, then standby.
// R03: Reset re-assertion aborts all write activity.
// R04: Stop enters standby unless programming runs.
// R05: Write-protect high makes array read-only.
// R06: Write-protect low allows normal writes.
// R07: Unlock input disables write-protect effect.
// R08: Select pins form part of address.
// R09: Unconnected select pins count as zero; there is no pull-down, so after reset a floating pin passes through as sampled.
// R10: Data line only pulled low, never high.
// R11: Programming completes alone within 4 ms.
// R12: Partial pages program only received bytes.
// R13: ID page writable until locked, then read-only.
// R14: Operate at bus clock up to 1 MHz.
// R15: Slave byte, word address, then data.
// R16: Bits move only with master's clock.
// R17: Start and stop conditions; silent until start.
// R18: Prefix 1010 main, 1011 ID, bit0 reads.
// R19: Page write increments low nibble, wraps.
// R20: No address acknowledge while programming.
// R21: Read pointer wraps from last to zero.
`timescale 1ns/100ps
module eeprom_slave #(
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES,
  parameter bit ID_PAGE_EN = 1'b1
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  input wire logic WP_IN,
  input wire logic WP_UNLOCK_IN,
  input wire logic ADDR_SELECT_BIT0_IN,
  input wire logic ADDR_SELECT_BIT1_IN,
  input wire logic ADDR_SELECT_BIT2_IN,
  output logic BUSY_OUT,
  output logic STANDBY_OUT
);
  import eeprom_pkg::*;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  // ==========================================================================
  // Pin sampling and bus conditions
  // ==========================================================================
  pins_t raw;
  pins_t p;
  pins_t prev_r;

  assign raw = '{scl: SCL_IN, sda: SDA_IN, wp: WP_IN, unlock: WP_UNLOCK_IN,
                 sel: {ADDR_SELECT_BIT2_IN, ADDR_SELECT_BIT1_IN, ADDR_SELECT_BIT0_IN}};

  // Select pins reset to zero; after reset a floating pin passes through as sampled, so reading zero needs a pull-down.
  pin_sync #(.W($bits(pins_t)), .RESET_VAL(PINS_RESET)) u_sync ( // R09 R14
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .async_in(raw),
    .sync_out(p)
  );

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      prev_r <= PINS_RESET;
    end else begin
      prev_r <= p;
    end
  end

  wire scl_rise = p.scl && !prev_r.scl; // R16
  wire scl_fall = !p.scl && prev_r.scl;
  wire start_cond = p.scl && prev_r.scl && prev_r.sda && !p.sda; // R17
  wire stop_cond = p.scl && prev_r.scl && !prev_r.sda && p.sda; // R17

  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [7:0] mem [MEM_DEPTH]; // R01
  logic [7:0] id_mem [PAGE_BYTES];
  logic [7:0] page_buf [PAGE_BYTES];
  // The lock models a non-volatile fuse, so the power-on reset leaves it alone.
  logic id_lock_r = 1'b0;

  // ==========================================================================
  // Protocol state
  // ==========================================================================
  slave_state_t state_r, state_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [PAGE_BYTES-1:0] mask_r, mask_nxt;
  logic oe_r, oe_nxt;
  logic tgt_id_r, tgt_id_nxt;
  logic lock_sel_r, lock_sel_nxt;
  logic mack_r, mack_nxt;
  logic sda_level_r;
  logic standby_r;
  logic busy;
  logic prog_done;

  wire byte_done = scl_fall && bit_cnt_r == BIT_LAST;
  wire ack_done = scl_fall && bit_cnt_r == ACK_SLOT;
  wire [3:0] prefix = shift_r[7:4];
  wire prefix_ok = prefix == PREFIX_MAIN || (ID_PAGE_EN && prefix == PREFIX_ID); // R18
  wire dev_match = prefix_ok && shift_r[3:1] == p.sel; // R08
  wire dev_ack = dev_match && !busy; // R20
  wire rx_state = state_r == ST_DEVADDR || state_r == ST_WORDADDR || state_r == ST_WRDATA;
  wire wr_byte = state_r == ST_WRDATA && byte_done && !start_cond && !stop_cond;
  wire [ADDR_W-1:0] page_next = {addr_r[7:4], addr_r[3:0] + 4'h1}; // R19
  wire [ADDR_W-1:0] rd_addr = (state_r == ST_RDDATA) ? addr_r + 8'h01 : addr_r; // R21
  wire [7:0] rd_byte = tgt_id_r ? id_mem[rd_addr[3:0]] : mem[rd_addr];
  wire wp_ok = !p.wp || p.unlock; // R05 R06 R07
  wire wr_ok = tgt_id_r ? (!id_lock_r && wp_ok) : wp_ok; // R13
  wire start_prog = stop_cond && state_r == ST_WRDATA && (|mask_r) && wr_ok && !busy;

  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    addr_nxt = addr_r;
    mask_nxt = mask_r;
    oe_nxt = oe_r;
    tgt_id_nxt = tgt_id_r;
    lock_sel_nxt = lock_sel_r;
    mack_nxt = mack_r;
    if (start_cond) begin
      state_nxt = ST_DEVADDR;
      bit_cnt_nxt = BIT_FIRST;
      oe_nxt = 1'b0;
      // A polling start while the cells program must not forget the bytes in flight.
      mask_nxt = (busy || prog_done) ? mask_r : '0;
    end else if (stop_cond) begin
      state_nxt = ST_IDLE; // R04
      bit_cnt_nxt = BIT_FIRST;
      oe_nxt = 1'b0;
    end else if (rx_state) begin
      if (scl_rise && bit_cnt_r < BIT_LAST) begin
        shift_nxt = {shift_r[6:0], p.sda};
        bit_cnt_nxt = bit_cnt_r + 4'h1;
      end else if (byte_done) begin
        bit_cnt_nxt = ACK_SLOT;
        oe_nxt = (state_r != ST_DEVADDR) || dev_ack; // R20
        if (state_r == ST_WRDATA) begin
          mask_nxt = mask_r | (PAGE_BYTES'(1) << addr_r[3:0]); // R12
          addr_nxt = page_next; // R19
        end
      end else if (ack_done) begin
        bit_cnt_nxt = BIT_FIRST;
        oe_nxt = 1'b0;
        case (state_r)
          ST_DEVADDR: begin
            if (!oe_r) begin
              state_nxt = ST_IGNORE;
            end else if (shift_r[0]) begin
              state_nxt = ST_RDDATA; // R18
              tgt_id_nxt = shift_r[4];
              tx_nxt = tgt_id_nxt ? id_mem[addr_r[3:0]] : mem[addr_r];
              oe_nxt = !tx_nxt[7];
            end else begin
              state_nxt = ST_WORDADDR; // R15
              tgt_id_nxt = shift_r[4];
            end
          end
          ST_WORDADDR: begin
            state_nxt = ST_WRDATA;
            addr_nxt = shift_r;
            lock_sel_nxt = tgt_id_r && shift_r[ID_LOCK_BIT];
          end
          default: begin
            state_nxt = state_r;
          end
        endcase
      end
    end else if (state_r == ST_RDDATA) begin
      if (scl_rise && bit_cnt_r < BIT_LAST) begin
        bit_cnt_nxt = bit_cnt_r + 4'h1;
      end else if (scl_rise && bit_cnt_r == BIT_LAST) begin
        mack_nxt = !p.sda;
        bit_cnt_nxt = ACK_SLOT;
      end else if (scl_fall && bit_cnt_r > BIT_FIRST && bit_cnt_r < BIT_LAST) begin
        oe_nxt = !tx_r[3'(4'h7 - bit_cnt_r)];
      end else if (byte_done) begin
        oe_nxt = 1'b0;
      end else if (ack_done) begin
        bit_cnt_nxt = BIT_FIRST;
        if (mack_r) begin
          addr_nxt = rd_addr; // R21
          tx_nxt = rd_byte;
          oe_nxt = !rd_byte[7];
        end else begin
          state_nxt = ST_IGNORE;
          oe_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      state_r <= ST_IDLE; // R02 R03
      bit_cnt_r <= BIT_FIRST;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      addr_r <= 8'h00;
      mask_r <= '0;
      oe_r <= 1'b0;
      tgt_id_r <= 1'b0;
      lock_sel_r <= 1'b0;
      mack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      addr_r <= addr_nxt;
      mask_r <= mask_nxt;
      oe_r <= oe_nxt;
      tgt_id_r <= tgt_id_nxt;
      lock_sel_r <= lock_sel_nxt;
      mack_r <= mack_nxt;
    end
  end

  // ==========================================================================
  // Programming cycle
  // ==========================================================================
  // Reset clears the timer, so a cycle cut short by power-down never commits.
  prog_timer #(.CYCLES(PROG_CYCLES)) u_timer ( // R11 R03
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .start_in(start_prog),
    .busy_out(busy),
    .done_out(prog_done)
  );

  always_ff @(posedge CLK_SYS_IN) begin
    if (wr_byte) begin
      page_buf[addr_r[3:0]] <= shift_r;
    end
    if (prog_done && !lock_sel_r) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (mask_r[i] && tgt_id_r) begin
          id_mem[i] <= page_buf[i]; // R13
        end else if (mask_r[i]) begin
          mem[{addr_r[7:4], 4'(i)}] <= page_buf[i]; // R12
        end
      end
    end
    if (prog_done && lock_sel_r && tgt_id_r) begin
      id_lock_r <= 1'b1; // R13
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      sda_level_r <= 1'b0;
      standby_r <= 1'b1;
    end else begin
      sda_level_r <= 1'b0; // R10
      standby_r <= state_nxt == ST_IDLE && !busy && !start_prog; // R04
    end
  end

  assign SDA_OUT = sda_level_r;
  assign SDA_OE_OUT = oe_r;
  assign BUSY_OUT = busy;
  assign STANDBY_OUT = standby_r;

  // ==========================================================================
  // Checks
  // ==========================================================================
  reset_idle_a: assert property (@(posedge CLK_SYS_IN) disable iff (1'b0) // R02
    RST_IN |=> state_r == ST_IDLE && !SDA_OE_OUT && !BUSY_OUT)
    else $error("reset did not return the slave to standby");

  low_only_a: assert property (!SDA_OUT) // R10
    else $error("data line driven high");

  silent_idle_a: assert property (state_r == ST_IDLE |-> !SDA_OE_OUT) // R17
    else $error("data line pulled while idle");

  busy_nack_a: assert property ( // R20
    state_r == ST_DEVADDR && byte_done && busy && !start_cond && !stop_cond |=> !SDA_OE_OUT)
    else $error("address acknowledged during programming");

  addr_match_a: assert property ( // R08
    state_r == ST_DEVADDR && byte_done && !start_cond && !stop_cond && !dev_match
    |=> !SDA_OE_OUT)
    else $error("foreign address acknowledged");

  protect_hold_a: assert property ($rose(BUSY_OUT) |-> $past(wr_ok)) // R05
    else $error("write started while protected");

  page_wrap_a: assert property (wr_byte |=> // R19
    addr_r[7:4] == $past(addr_r[7:4]) && addr_r[3:0] == $past(addr_r[3:0]) + 4'h1)
    else $error("page write pointer left its page");

  read_wrap_a: assert property ( // R21
    state_r == ST_RDDATA && ack_done && mack_r && !start_cond && !stop_cond
    |=> addr_r == $past(addr_r) + 8'h01)
    else $error("read pointer did not advance");

  stop_standby_a: assert property (stop_cond && !busy && !start_prog |=> ##1 STANDBY_OUT) // R04
    else $error("stop did not enter standby");

  stop_prog_a: assert property (start_prog |=> BUSY_OUT && !STANDBY_OUT) // R04
    else $error("standby entered with programming pending");

endmodule

// *** sim/i2c_master_model.sv ***
/*
  Behavioural two-wire bus master that drives the clock and an open-drain data line.
  Assumes the bench resolves the data wire from this model and the slave's enable.
*/
`timescale 1ns/100ps
module i2c_master_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // ==========================================================================
  // Bus timing
  // ==========================================================================
  // Eight system clocks per bit give an 80 ns bus clock, far above the 1 MHz
  // ceiling, so the run stresses the slave's sampling margin with four clocks a phase.
  localparam int QTR = 2;

  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // ==========================================================================
  // Conditions and bits
  // ==========================================================================
  task automatic start();
    sda_out <= 1'b1;
    tick(QTR);
    scl_out <= 1'b1;
    tick(QTR);
    sda_out <= 1'b0;
    tick(QTR);
    scl_out <= 1'b0;
    tick(QTR);
  endtask

  task automatic stop();
    sda_out <= 1'b0;
    tick(QTR);
    scl_out <= 1'b1;
    tick(QTR);
    sda_out <= 1'b1;
    tick(2 * QTR);
  endtask

  // Data only changes while the clock is low, so no bit looks like a condition.
  task automatic bit_xfer(input logic b, output logic r);
    sda_out <= b;
    tick(QTR);
    scl_out <= 1'b1;
    tick(QTR);
    r = sda_in;
    tick(QTR);
    scl_out <= 1'b0;
    tick(QTR);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(output logic [7:0] d, input logic mack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, d[i]);
    end
    bit_xfer(~mack, r);
  endtask
endmodule

// *** sim/eeprom_slave_tb.sv ***
/*
  Self-checking bench for the serial EEPROM slave, driven through the master model.
  Assumes a pull-up on the data wire and a shortened programming time.
*/
`timescale 1ns/100ps
module eeprom_slave_tb;
  import eeprom_pkg::*;
  localparam int PROG = 600;
  localparam int LIMIT = 40000;
  logic clk, rst, wp, unlock, scl, sda_m, sda_oe, sda_do, busy, stby, a;
  logic r10_bad = 1'b0;
  logic [2:0] sel;
  logic [7:0] rbuf [0:15];
  wire logic sda_w = sda_m & ~sda_oe;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  eeprom_slave #(.PROG_CYCLES(PROG)) DUT (
    .CLK_SYS_IN(clk),
    .RST_IN(rst),
    .SCL_IN(scl),
    .SDA_IN(sda_w),
    .SDA_OUT(sda_do),
    .SDA_OE_OUT(sda_oe),
    .WP_IN(wp),
    .WP_UNLOCK_IN(unlock),
    .ADDR_SELECT_BIT0_IN(sel[0]),
    .ADDR_SELECT_BIT1_IN(sel[1]),
    .ADDR_SELECT_BIT2_IN(sel[2]),
    .BUSY_OUT(busy),
    .STANDBY_OUT(stby)
  );
  i2c_master_model master (
    .clk_in(clk),
    .sda_in(sda_w),
    .scl_out(scl),
    .sda_out(sda_m)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (sda_oe === 1'b1 && sda_do !== 1'b0) begin
      r10_bad <= 1'b1;
    end
    if (cycles == LIMIT) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic addr_only(input logic [7:0] dev);
    master.start();
    master.wr_byte(dev, a);
    master.stop();
  endtask

  task automatic wr(input logic [7:0] dev, input logic [7:0] ad, input int n, input logic [7:0] d0);
    master.start();
    master.wr_byte(dev, a);
    check({7'h0, a}, 8'h01);
    master.wr_byte(ad, a);
    check({7'h0, a}, 8'h01);
    for (int i = 0; i < n; i++) begin
      master.wr_byte(d0 + 8'(i), a);
      check({7'h0, a}, 8'h01);
    end
    master.stop();
  endtask

  task automatic rd(input logic [7:0] dev, input logic [7:0] ad, input int n);
    master.start();
    master.wr_byte(dev, a);
    master.wr_byte(ad, a);
    master.start();
    master.wr_byte(dev | 8'h01, a);
    check({7'h0, a}, 8'h01);
    for (int i = 0; i < n; i++) begin
      master.rd_byte(rbuf[i], i < n - 1);
    end
    master.stop();
  endtask

  // A protected or refused write must leave the device in standby with no cycle.
  task automatic prog_wait(input logic exp_busy);
    int n;
    n = 0;
    master.tick(2);
    check({7'h0, busy}, {7'h0, exp_busy});
    check({7'h0, stby}, {7'h0, ~exp_busy});
    while (busy === 1'b1 && n < PROG + 50) begin
      master.tick(1);
      n++;
    end
    check({7'h0, busy}, 8'h00);
    master.tick(2);
    check({7'h0, stby}, 8'h01);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    check({6'h0, busy, sda_oe}, 8'h00);
    check({7'h0, stby}, 8'h01);
    rst <= 1'b1;
    addr_only(8'hA0);
    check({7'h0, a}, 8'h00);
    rst <= 1'b0;
    master.tick(4);
    $display("reset test done");
  endtask

  task automatic t_byte();
    wr(8'hA0, 8'h10, 1, 8'h5A);
    addr_only(8'hA0);
    check({7'h0, a}, 8'h00);
    prog_wait(1'b1);
    rd(8'hA0, 8'h10, 1);
    check(rbuf[0], 8'h5A);
    $display("byte write test done");
  endtask

  task automatic t_page();
    logic [7:0] e;
    wr(8'hA0, 8'h30, 16, 8'h00);
    prog_wait(1'b1);
    wr(8'hA0, 8'h3E, 4, 8'h80);
    prog_wait(1'b1);
    rd(8'hA0, 8'h30, 16);
    for (int i = 0; i < 16; i++) begin
      e = (i >= 14) ? 8'h80 + 8'(i - 14) : (i < 2) ? 8'h82 + 8'(i) : 8'(i);
      check(rbuf[i], e);
    end
    $display("page write test done");
  endtask

  task automatic t_wrap();
    wr(8'hA0, 8'hFF, 1, 8'hF1);
    prog_wait(1'b1);
    wr(8'hA0, 8'h00, 1, 8'h0F);
    prog_wait(1'b1);
    rd(8'hA0, 8'hFF, 2);
    check(rbuf[0], 8'hF1);
    check(rbuf[1], 8'h0F);
    $display("pointer wrap test done");
  endtask

  task automatic t_protect();
    wp <= 1'b1;
    wr(8'hA0, 8'h10, 1, 8'hEE);
    prog_wait(1'b0);
    rd(8'hA0, 8'h10, 1);
    check(rbuf[0], 8'h5A);
    unlock <= 1'b1;
    wr(8'hA0, 8'h10, 1, 8'h66);
    prog_wait(1'b1);
    rd(8'hA0, 8'h10, 1);
    check(rbuf[0], 8'h66);
    wp <= 1'b0;
    unlock <= 1'b0;
    $display("write protect test done");
  endtask

  task automatic t_select();
    for (int s = 0; s < 8; s++) begin
      sel <= 3'(s);
      master.tick(4);
      addr_only(8'hA0 | 8'(s << 1));
      check({7'h0, a}, 8'h01);
      addr_only(8'hA0 | 8'((s ^ 1) << 1));
      check({7'h0, a}, 8'h00);
    end
    sel <= 3'h0;
    master.tick(4);
    addr_only(8'hC0);
    check({7'h0, a}, 8'h00);
    addr_only(8'hA0);
    check({7'h0, a}, 8'h01);
    $display("address select test done");
  endtask

  task automatic t_id();
    wr(8'hB0, 8'h05, 1, 8'h77);
    prog_wait(1'b1);
    rd(8'hB0, 8'h05, 1);
    check(rbuf[0], 8'h77);
    wr(8'hB0, 8'h80, 1, 8'h00);
    prog_wait(1'b1);
    wr(8'hB0, 8'h05, 1, 8'h11);
    prog_wait(1'b0);
    rd(8'hB0, 8'h05, 1);
    check(rbuf[0], 8'h77);
    $display("identification page test done");
  endtask

  task automatic t_powerfail();
    wr(8'hA0, 8'h40, 1, 8'h12);
    prog_wait(1'b1);
    wr(8'hA0, 8'h40, 1, 8'h99);
    master.tick(20);
    rst <= 1'b1;
    master.tick(4);
    check({6'h0, busy, stby}, 8'h01);
    rst <= 1'b0;
    master.tick(4);
    rd(8'hA0, 8'h40, 1);
    check(rbuf[0], 8'h12);
    $display("power fail test done");
  endtask

  initial begin
    rst = 1'b1;
    wp = 1'b0;
    unlock = 1'b0;
    sel = 3'h0;
    master.tick(5);
    rst <= 1'b0;
    master.tick(4);
    t_reset();
    t_byte();
    t_page();
    t_wrap();
    t_protect();
    t_select();
    t_id();
    t_powerfail();
    check({7'h0, r10_bad}, 8'h00);
    end_of_test();
  end
endmodule
